// ===== drwt_ctrl_model.sv
// Purpose: controller-side model that issues training commands and write bursts
// Assumes: commands and data change on the falling edge of mclk
// Notes:   write data lines show the inverted last beat between bursts, 16'ha5a5 before the first
`timescale 1ns/10ps
`include "drwt_params.svh"

module drwt_ctrl_model (
  input  logic                mclk,       // command clock
  input  logic [5:0]          wl,         // write latency in use
  output logic                cmd_valid,  // command start
  output drwt_pkg::drwt_cmd_t cmd_code,   // decoded command
  output logic [5:0]          cmd_ma,     // mode register address
  output logic [7:0]          cmd_op,     // operand
  output logic [15:0]         dq_in,      // write data beat
  output logic [1:0]          dmi_in      // write dmi beat
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = drwt_pkg::DRWT_CMD_DES;
    cmd_ma    = 6'h00;
    cmd_op    = 8'h00;
    dq_in     = 16'ha5a5;
    dmi_in    = 2'h1;
  end

  // beat value as {dmi, dq}
  function automatic logic [17:0] beat_val(input logic [7:0] seed, input logic [3:0] b);
    return {b[1:0] ^ seed[1:0], seed, 4'h9, b};
  endfunction : beat_val

  task automatic issue(input drwt_pkg::drwt_cmd_t code, input logic [5:0] ma,
                       input logic [7:0] op);
    @(negedge mclk);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    cmd_ma    <= ma;
    cmd_op    <= op;
  endtask : issue

  task automatic release_cmd();
    @(negedge mclk);
    cmd_valid <= 1'b0;
    cmd_code  <= drwt_pkg::DRWT_CMD_DES;
  endtask : release_cmd

  task automatic mrw(input logic [5:0] ma, input logic [7:0] op);
    issue(drwt_pkg::DRWT_CMD_MRW, ma, op);
    release_cmd();
  endtask : mrw

  // cas-2 follows in the very next slot with all operands low
  task automatic pair(input logic [7:0] op);
    issue(drwt_pkg::DRWT_CMD_MPC, 6'h00, op);
    issue(drwt_pkg::DRWT_CMD_CAS2, 6'h00, 8'h00);
    release_cmd();
  endtask : pair

  task automatic wr_fifo(input logic [7:0] seed);
    pair({2'b01, `DRWT_FN_WRFIFO});
    repeat (wl) @(negedge mclk);
    for (int b = 0; b < 16; b++) begin
      if (b > 0) @(negedge mclk);
      {dmi_in, dq_in} <= beat_val(seed, b[3:0]);
    end
    @(negedge mclk);
    dq_in  <= ~dq_in;
    dmi_in <= ~dmi_in;
  endtask : wr_fifo
endmodule : drwt_ctrl_model

// ===== drwt_fifo_mem.sv
// Purpose: five-entry training fifo storage, 16 beats of 18 pins each
// Assumes: entry index never above 4
// Notes:   read port is combinational
`timescale 1ns/10ps
`include "drwt_params.svh"

module drwt_fifo_mem (
  input  logic                   mclk,    // command clock
  input  logic                   rst,     // synchronous reset
  input  logic                   clr,     // wipe all entries
  input  logic                   we,      // write one beat
  input  logic [2:0]             w_ent,   // entry written
  input  logic [3:0]             w_beat,  // beat written
  input  logic [`DRWT_PIN_W-1:0] w_data,  // captured pins
  input  logic [2:0]             r_ent,   // entry read
  input  logic [3:0]             r_beat,  // beat read
  output logic [`DRWT_PIN_W-1:0] r_data   // stored pins
);

  logic [`DRWT_PIN_W-1:0] mem_r [0:`DRWT_MEM_WORDS-1];
  wire  [6:0]             w_idx;
  wire  [6:0]             r_idx;

  assign w_idx  = {w_ent, w_beat};
  assign r_idx  = {r_ent, r_beat};
  assign r_data = mem_r[r_idx];

  always_ff @(posedge mclk) begin
    for (int i = 0; i < `DRWT_MEM_WORDS; i++) begin
      if (rst || clr) begin
        mem_r[i] <= '0;
      end else if (we && (w_idx == 7'(i))) begin
        mem_r[i] <= w_data;
      end
    end
  end

endmodule : drwt_fifo_mem

// ===== drwt_params.svh
// Purpose: constants of the read/write training block
// Assumes: included by bare name from every design file except the package
// Notes:   mode register numbers double as the command address
`ifndef DRWT_PARAMS_SVH
`define DRWT_PARAMS_SVH

`define DRWT_MA_DBI      6'h03
`define DRWT_MA_INV_LO   6'h0f
`define DRWT_MA_INV_HI   6'h14
`define DRWT_MA_PAT_1    6'h20
`define DRWT_MA_PAT_2    6'h28

`define DRWT_RST_PAT_1   8'h5a
`define DRWT_RST_PAT_2   8'h3c
`define DRWT_RST_INV_LO  8'h55
`define DRWT_RST_INV_HI  8'h55
`define DRWT_RST_DBI     8'h00

`define DRWT_READ_INVERSION_ENABLE_BIT  6
`define DRWT_MPC_EN_BIT  6
`define DRWT_FN_RDFIFO   6'h01
`define DRWT_FN_RDCAL    6'h03
`define DRWT_FN_WRFIFO   6'h07

`define DRWT_LAST_ENT    3'h4
`define DRWT_LAST_BEAT   4'hf
`define DRWT_MEM_WORDS   80
`define DRWT_PIN_W       18
`define DRWT_LAT_DEPTH   64

`endif

// ===== drwt_pkg.sv
// Purpose: types shared by the training block
// Assumes: nothing
// Notes:   command codes come from the command decoder
package drwt_pkg;

  typedef enum logic [2:0] {
    DRWT_CMD_DES,
    DRWT_CMD_MPC,
    DRWT_CMD_CAS2,
    DRWT_CMD_MRW,
    DRWT_CMD_MRR,
    DRWT_CMD_RD,
    DRWT_CMD_WR,
    DRWT_CMD_MWR
  } drwt_cmd_t;

  typedef enum logic [1:0] {
    DRWT_BK_NONE,
    DRWT_BK_CAL,
    DRWT_BK_RFIFO
  } drwt_burst_t;

endpackage : drwt_pkg

// ===== drwt_training.sv
// Purpose: read calibration pattern source and write/read training fifo
// Assumes: commands arrive decoded, one cycle per command start
// Notes:   one data beat per mclk; a burst is 16 cycles
`timescale 1ns/10ps
`include "drwt_params.svh"

module drwt_training (
  input  logic                mclk,                // command clock
  input  logic                rst,                 // synchronous reset
  input  logic                cmd_valid,           // command start
  input  drwt_pkg::drwt_cmd_t cmd_code,            // decoded command
  input  logic [5:0]          cmd_ma,              // mode register address
  input  logic [7:0]          cmd_op,              // operand
  input  logic                cke_pin,             // clock enable pin
  input  logic                pd_entry,            // power-down entry pulse
  input  logic                srpd_entry,          // self-refresh pd entry pulse
  input  logic [5:0]          read_delay_cycles,   // read latency
  input  logic [5:0]          write_delay_cycles,  // write latency
  input  logic [15:0]         dq_in,               // captured write data
  input  logic [1:0]          dmi_in,              // captured write dmi
  output logic [15:0]         dq_out,              // data lanes out
  output logic                dq_oe_n,             // low while driving lanes
  output logic [1:0]          dmi_out,             // dmi out
  output logic [1:0]          dmi_oe_n             // low while driving dmi
);

  function automatic logic [2:0] ptr_inc(input logic [2:0] p);
    ptr_inc = (p == `DRWT_LAST_ENT) ? 3'h0 : p + 3'h1;
  endfunction : ptr_inc

  function automatic logic ma_hit(input logic wr, input logic [5:0] ma,
                                  input logic [5:0] sel);
    ma_hit = wr && (ma == sel);
  endfunction : ma_hit

  logic                  cke_m_r;
  logic                  cke_s_r;
  logic                  mpc_pend_r;
  logic [5:0]            mpc_fn_r;
  logic [2:0]            wptr_r;
  logic [2:0]            rptr_r;
  logic [7:0]            pat1_r;
  logic [7:0]            pat2_r;
  logic [7:0]            inv_lo_r;
  logic [7:0]            inv_hi_r;
  logic [7:0]            dbi_r;
  drwt_pkg::drwt_burst_t rk_r   [0:`DRWT_LAT_DEPTH-1];
  drwt_pkg::drwt_burst_t rk_nxt [0:`DRWT_LAT_DEPTH-1];
  logic [2:0]            re_r   [0:`DRWT_LAT_DEPTH-1];
  logic [2:0]            re_nxt [0:`DRWT_LAT_DEPTH-1];
  logic                  wv_r   [0:`DRWT_LAT_DEPTH-1];
  logic                  wv_nxt [0:`DRWT_LAT_DEPTH-1];
  logic [2:0]            we_r   [0:`DRWT_LAT_DEPTH-1];
  logic [2:0]            we_nxt [0:`DRWT_LAT_DEPTH-1];
  logic                  ract_r;
  logic [3:0]            rb_r;
  drwt_pkg::drwt_burst_t rkind_r;
  logic [2:0]            rent_r;
  logic                  wact_r;
  logic [3:0]            wb_r;
  logic [2:0]            went_r;
  logic [15:0]           dq_out_r;
  logic [1:0]            dmi_out_r;
  logic                  dq_oe_n_r;
  logic [1:0]            dmi_oe_n_r;
  drwt_pkg::drwt_burst_t out_kind_r;

  // command acceptance, ignored while cke is low
  wire acc    = cmd_valid && cke_s_r;
  wire c_mpc  = acc && (cmd_code == drwt_pkg::DRWT_CMD_MPC);
  wire c_cas2 = acc && (cmd_code == drwt_pkg::DRWT_CMD_CAS2);
  wire c_mrw  = acc && (cmd_code == drwt_pkg::DRWT_CMD_MRW);
  wire c_mrr  = acc && (cmd_code == drwt_pkg::DRWT_CMD_MRR);
  wire c_rd   = acc && (cmd_code == drwt_pkg::DRWT_CMD_RD);
  wire c_wr   = acc && (cmd_code == drwt_pkg::DRWT_CMD_WR);
  wire c_mwr  = acc && (cmd_code == drwt_pkg::DRWT_CMD_MWR);

  wire [5:0] fn     = cmd_op[5:0];
  wire fn_known     = (fn == `DRWT_FN_RDFIFO) || (fn == `DRWT_FN_RDCAL) ||
                      (fn == `DRWT_FN_WRFIFO);
  wire mpc_train    = c_mpc && cmd_op[`DRWT_MPC_EN_BIT] && fn_known;
  // cas-2 completes a pair as long as no other accepted command comes between it and the mpc
  wire go           = c_cas2 && mpc_pend_r;
  wire go_cal       = go && (mpc_fn_r == `DRWT_FN_RDCAL);
  wire go_rf        = go && (mpc_fn_r == `DRWT_FN_RDFIFO);
  wire go_wf        = go && (mpc_fn_r == `DRWT_FN_WRFIFO);
  wire mpc_pend_nxt = mpc_train ? 1'b1 : (acc ? 1'b0 : mpc_pend_r);

  wire ptr_rst       = pd_entry || srpd_entry;
  wire [2:0] wptr_nx = ptr_rst ? 3'h0 :
                       (go_wf || c_rd) ? ptr_inc(wptr_r) : wptr_r;
  wire [2:0] rptr_nx = (go_rf || c_rd) ? ptr_inc(rptr_r) : rptr_r;
  // contents wiped by disturbing commands, never by fifo reads
  wire mem_clr = c_wr || c_mwr || c_rd || c_mrr || go_cal || !cke_s_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      cke_m_r    <= 1'b0;
      cke_s_r    <= 1'b0;
      mpc_pend_r <= 1'b0;
      mpc_fn_r   <= 6'h00;
      wptr_r     <= 3'h0;
      rptr_r     <= 3'h0;
    end else begin
      cke_m_r    <= cke_pin;
      cke_s_r    <= cke_m_r;
      mpc_pend_r <= mpc_pend_nxt;
      mpc_fn_r   <= mpc_train ? fn : mpc_fn_r;
      wptr_r     <= wptr_nx;
      rptr_r     <= rptr_nx;
    end
  end

  // mode registers written by mrw
  always_ff @(posedge mclk) begin
    if (rst) begin
      pat1_r   <= `DRWT_RST_PAT_1;
      pat2_r   <= `DRWT_RST_PAT_2;
      inv_lo_r <= `DRWT_RST_INV_LO;
      inv_hi_r <= `DRWT_RST_INV_HI;
      dbi_r    <= `DRWT_RST_DBI;
    end else begin
      if (ma_hit(c_mrw, cmd_ma, `DRWT_MA_PAT_1)) pat1_r <= cmd_op;
      if (ma_hit(c_mrw, cmd_ma, `DRWT_MA_PAT_2)) pat2_r <= cmd_op;
      if (ma_hit(c_mrw, cmd_ma, `DRWT_MA_INV_LO)) inv_lo_r <= cmd_op;
      if (ma_hit(c_mrw, cmd_ma, `DRWT_MA_INV_HI)) inv_hi_r <= cmd_op;
      if (ma_hit(c_mrw, cmd_ma, `DRWT_MA_DBI)) dbi_r <= cmd_op;
    end
  end

  // latency lines: slot n starts its burst n+1 edges later
  wire                   rd_ins = go_cal || go_rf;
  drwt_pkg::drwt_burst_t rk_new;
  assign rk_new = go_cal ? drwt_pkg::DRWT_BK_CAL : drwt_pkg::DRWT_BK_RFIFO;

  for (genvar gi = 0; gi < `DRWT_LAT_DEPTH; gi++) begin : g_lat
    wire hit_r = rd_ins && (read_delay_cycles == 6'(gi));
    wire hit_w = go_wf && (write_delay_cycles == 6'(gi));
    if (gi == `DRWT_LAT_DEPTH - 1) begin : g_end
      assign rk_nxt[gi] = hit_r ? rk_new : drwt_pkg::DRWT_BK_NONE;
      assign re_nxt[gi] = hit_r ? rptr_r : 3'h0;
      assign wv_nxt[gi] = hit_w;
      assign we_nxt[gi] = hit_w ? wptr_r : 3'h0;
    end else begin : g_mid
      assign rk_nxt[gi] = hit_r ? rk_new : rk_r[gi+1];
      assign re_nxt[gi] = hit_r ? rptr_r : re_r[gi+1];
      assign wv_nxt[gi] = hit_w || wv_r[gi+1];
      assign we_nxt[gi] = hit_w ? wptr_r : we_r[gi+1];
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < `DRWT_LAT_DEPTH; i++) begin
      rk_r[i] <= rst ? drwt_pkg::DRWT_BK_NONE : rk_nxt[i];
      re_r[i] <= rst ? 3'h0 : re_nxt[i];
      wv_r[i] <= rst ? 1'b0 : wv_nxt[i];
      we_r[i] <= rst ? 3'h0 : we_nxt[i];
    end
  end

  // read burst engine; a new start restarts the beat count seamlessly
  wire                   rd_start = (rk_r[0] != drwt_pkg::DRWT_BK_NONE);
  wire [3:0]             rbeat    = rd_start ? 4'h0 : rb_r;
  wire [2:0]             rent     = rd_start ? re_r[0] : rent_r;
  wire                   rdrive   = rd_start || ract_r;
  drwt_pkg::drwt_burst_t rkind;
  assign rkind = rdrive ? (rd_start ? rk_r[0] : rkind_r) : drwt_pkg::DRWT_BK_NONE;

  wire        is_cal   = (rkind == drwt_pkg::DRWT_BK_CAL);
  wire [7:0]  cal_byte = rbeat[3] ? pat2_r : pat1_r;
  wire        cal_bit  = cal_byte[rbeat[2:0]];
  wire [15:0] inv_mask = {inv_hi_r, inv_lo_r};
  // plain pattern xor mask, no bus inversion applied
  wire [15:0] cal_dq   = {16{cal_bit}} ^ inv_mask;
  wire [`DRWT_PIN_W-1:0] mem_rdata;
  wire [15:0] dq_nx    = !rdrive ? 16'h0000 : (is_cal ? cal_dq : mem_rdata[15:0]);
  wire [1:0]  dmi_nx   = !rdrive ? 2'h0 : (is_cal ? {2{cal_bit}} : mem_rdata[17:16]);
  wire        dmi_en   = rdrive && (!is_cal || dbi_r[`DRWT_READ_INVERSION_ENABLE_BIT]);
  wire        ract_nx  = rdrive && (rbeat != `DRWT_LAST_BEAT);

  always_ff @(posedge mclk) begin
    if (rst) begin
      ract_r     <= 1'b0;
      rb_r       <= 4'h0;
      rkind_r    <= drwt_pkg::DRWT_BK_NONE;
      rent_r     <= 3'h0;
      dq_out_r   <= 16'h0000;
      dmi_out_r  <= 2'h0;
      dq_oe_n_r  <= 1'b1;
      dmi_oe_n_r <= 2'h3;
      out_kind_r <= drwt_pkg::DRWT_BK_NONE;
    end else begin
      ract_r     <= ract_nx;
      rb_r       <= rbeat + 4'h1;
      rkind_r    <= rkind;
      rent_r     <= rent;
      dq_out_r   <= dq_nx;
      dmi_out_r  <= dmi_en ? dmi_nx : 2'h0;
      dq_oe_n_r  <= !rdrive;
      dmi_oe_n_r <= {2{!dmi_en}};
      out_kind_r <= rkind;
    end
  end

  // write capture engine
  wire       wr_start = wv_r[0];
  wire [3:0] wbeat    = wr_start ? 4'h0 : wb_r;
  wire [2:0] went     = wr_start ? we_r[0] : went_r;
  wire       mem_we   = wr_start || wact_r;
  wire       wact_nx  = mem_we && (wbeat != `DRWT_LAST_BEAT);

  always_ff @(posedge mclk) begin
    if (rst) begin
      wact_r <= 1'b0;
      wb_r   <= 4'h0;
      went_r <= 3'h0;
    end else begin
      wact_r <= wact_nx;
      wb_r   <= wbeat + 4'h1;
      went_r <= went;
    end
  end

  // unwritten entries read back their cleared, defined value
  drwt_fifo_mem u_mem (
    .mclk   (mclk),
    .rst    (rst),
    .clr    (mem_clr),
    .we     (mem_we),
    .w_ent  (went),
    .w_beat (wbeat),
    .w_data ({dmi_in, dq_in}),
    .r_ent  (rent),
    .r_beat (rbeat),
    .r_data (mem_rdata)
  );

  assign dq_out   = dq_out_r;
  assign dq_oe_n  = dq_oe_n_r;
  assign dmi_out  = dmi_out_r;
  assign dmi_oe_n = dmi_oe_n_r;

  // checks
  wire lane0 = dq_out_r[0] ^ inv_lo_r[0];
  wire cal_go = rd_start && (rk_r[0] == drwt_pkg::DRWT_BK_CAL) && !ract_r;

  property p_cal_uniform;
    @(posedge mclk) disable iff (rst)
    (out_kind_r == drwt_pkg::DRWT_BK_CAL) |->
      (((dq_out_r ^ $past(inv_mask)) == 16'h0000) ||
       ((dq_out_r ^ $past(inv_mask)) == 16'hffff));
  endproperty
  a_cal_uniform: assert property (p_cal_uniform) else $error("lane inversion wrong");

  property p_dmi_plain;
    @(posedge mclk) disable iff (rst)
    (out_kind_r == drwt_pkg::DRWT_BK_CAL && dmi_oe_n_r == 2'h0) |->
      (dmi_out_r == {2{dq_out_r[0] ^ $past(inv_lo_r[0])}});
  endproperty
  a_dmi_plain: assert property (p_dmi_plain) else $error("dmi pattern inverted");

  property p_dmi_off;
    @(posedge mclk) disable iff (rst)
    (out_kind_r == drwt_pkg::DRWT_BK_CAL && !$past(dbi_r[`DRWT_READ_INVERSION_ENABLE_BIT]))
      |-> (dmi_oe_n_r == 2'h3);
  endproperty
  a_dmi_off: assert property (p_dmi_off) else $error("dmi driven with inversion off");

  property p_lsb_first;
    @(posedge mclk) disable iff (rst)
    cal_go |=> (lane0 == $past(pat1_r[0])) ##1 (lane0 == $past(pat1_r[1], 2));
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("bit order wrong");

  property p_second_byte;
    @(posedge mclk) disable iff (rst)
    cal_go |=> ##8 (lane0 == $past(pat2_r[0], 9));
  endproperty
  a_second_byte: assert property (p_second_byte) else $error("second byte missing");

  property p_burst_len;
    @(posedge mclk) disable iff (rst)
    (rd_start && !ract_r) |=> !dq_oe_n_r [*8] ##1 !dq_oe_n_r [*8];
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst shorter than 16");

  property p_wrap;
    @(posedge mclk) disable iff (rst)
    (go_rf && !c_rd && rptr_r == `DRWT_LAST_ENT) |=> (rptr_r == 3'h0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("read pointer did not wrap");

  property p_pd_ptr;
    @(posedge mclk) disable iff (rst)
    ptr_rst |=> (wptr_r == 3'h0);
  endproperty
  a_pd_ptr: assert property (p_pd_ptr) else $error("write pointer not reset");

  property p_rd_adv;
    @(posedge mclk) disable iff (rst)
    (c_rd && !ptr_rst) |=>
      (wptr_r == ptr_inc($past(wptr_r))) && (rptr_r == ptr_inc($past(rptr_r)));
  endproperty
  a_rd_adv: assert property (p_rd_adv) else $error("array read did not advance");

  property p_mpc_nop;
    @(posedge mclk) disable iff (rst)
    (c_mpc && !cmd_op[`DRWT_MPC_EN_BIT]) |=> !mpc_pend_r ##1 !go;
  endproperty
  a_mpc_nop: assert property (p_mpc_nop) else $error("mpc nop started training");

  property p_ptr_range;
    @(posedge mclk) disable iff (rst)
    (wptr_r <= `DRWT_LAST_ENT) && (rptr_r <= `DRWT_LAST_ENT);
  endproperty
  a_ptr_range: assert property (p_ptr_range) else $error("pointer out of range");

  property p_cov_cal;
    @(posedge mclk) disable iff (rst) cal_go;
  endproperty
  c_cov_cal: cover property (p_cov_cal);

  property p_cov_wfifo;
    @(posedge mclk) disable iff (rst) wr_start;
  endproperty
  c_cov_wfifo: cover property (p_cov_wfifo);

  property p_cov_wrap;
    @(posedge mclk) disable iff (rst) go_rf && rptr_r == `DRWT_LAST_ENT;
  endproperty
  c_cov_wrap: cover property (p_cov_wrap);

  property p_cov_b2b;
    @(posedge mclk) disable iff (rst) rd_start && ract_r;
  endproperty
  c_cov_b2b: cover property (p_cov_b2b);

endmodule : drwt_training

// ===== drwt_training_tb.sv
// Purpose: self-checking bench for the read/write training block
// Assumes: inputs change on the falling edge; one beat per mclk
// Notes:   no mode register write stands between fifo writes and reads
`timescale 1ns/10ps
`include "drwt_params.svh"

module drwt_training_tb;
  logic                mclk, rst, cke_pin, pd_entry, srpd_entry;
  logic [5:0]          rl, wl;
  logic                cmd_valid;
  drwt_pkg::drwt_cmd_t cmd_code;
  logic [5:0]          cmd_ma;
  logic [7:0]          cmd_op;
  logic [15:0]         dq_in, dq_out;
  logic [1:0]          dmi_in, dmi_out, dmi_oe_n;
  logic                dq_oe_n;
  logic [20:0]         obs;
  logic [7:0]          pat1, pat2, m_lo, m_hi;
  logic                dbi_on;
  int                  n_fail, cmp_count;

  assign obs = {dmi_oe_n, dq_oe_n, dmi_out, dq_out};

  drwt_training u_drwt_training (
    .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ma(cmd_ma),
    .cmd_op(cmd_op), .cke_pin(cke_pin), .pd_entry(pd_entry), .srpd_entry(srpd_entry),
    .read_delay_cycles(rl), .write_delay_cycles(wl), .dq_in(dq_in), .dmi_in(dmi_in),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dmi_out(dmi_out), .dmi_oe_n(dmi_oe_n));

  drwt_ctrl_model u_drwt_ctrl_model (
    .mclk(mclk), .wl(wl), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ma(cmd_ma),
    .cmd_op(cmd_op), .dq_in(dq_in), .dmi_in(dmi_in));

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  task automatic finish_test();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [20:0] seen, input logic [20:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t out %h expected %h", $time, seen, exp);
    end
  endtask : check

  // lsb of each byte first, lanes xor their mask bit, dmi plain
  function automatic logic [17:0] cal_beat(input int b);
    logic [7:0] p;
    logic       v;
    p = (b < 8) ? pat1 : pat2;
    v = p[b % 8];
    return {dbi_on ? {2{v}} : 2'b00, {8{v}} ^ m_hi, {8{v}} ^ m_lo};
  endfunction : cal_beat

  task automatic expect_cal(input int n);
    repeat (rl + 1) @(negedge mclk);
    for (int b = 0; b < n; b++) begin
      if (b > 0) @(negedge mclk);
      check(obs, {dbi_on ? 2'b00 : 2'b11, 1'b0, cal_beat(b % 16)});
    end
    @(negedge mclk);
    check(obs, 21'h1c0000);
  endtask : expect_cal

  task automatic read_fifo(input logic [7:0] seed, input logic v);
    logic [17:0] exp_d;
    u_drwt_ctrl_model.pair({2'b01, `DRWT_FN_RDFIFO});
    repeat (rl + 1) @(negedge mclk);
    for (int b = 0; b < 16; b++) begin
      if (b > 0) @(negedge mclk);
      exp_d = v ? u_drwt_ctrl_model.beat_val(seed, b[3:0]) : 18'h0;
      check(obs, {3'b000, exp_d});
    end
  endtask : read_fifo

  task automatic pulse(input logic sr);
    @(negedge mclk);
    if (sr) srpd_entry <= 1'b1;
    else pd_entry <= 1'b1;
    @(negedge mclk);
    srpd_entry <= 1'b0;
    pd_entry   <= 1'b0;
  endtask : pulse

  task automatic t_defaults();
    {pat1, pat2, m_lo, m_hi, dbi_on} = {8'h5a, 8'h3c, 8'h55, 8'h55, 1'b0};
    u_drwt_ctrl_model.pair({2'b01, `DRWT_FN_RDCAL});
    expect_cal(16);
  endtask : t_defaults

  task automatic t_prog_b2b();
    {pat1, pat2, m_lo, m_hi, dbi_on} = {8'h1c, 8'h59, 8'h55, 8'h0f, 1'b1};
    u_drwt_ctrl_model.mrw(`DRWT_MA_PAT_1, pat1);
    u_drwt_ctrl_model.mrw(`DRWT_MA_PAT_2, pat2);
    u_drwt_ctrl_model.mrw(`DRWT_MA_INV_LO, m_lo);
    u_drwt_ctrl_model.mrw(`DRWT_MA_INV_HI, m_hi);
    u_drwt_ctrl_model.mrw(`DRWT_MA_DBI, 8'h40);
    u_drwt_ctrl_model.pair({2'b01, `DRWT_FN_RDCAL});
    fork
      begin
        repeat (13) @(negedge mclk);
        u_drwt_ctrl_model.pair({2'b01, `DRWT_FN_RDCAL});
      end
      expect_cal(32);
    join
    u_drwt_ctrl_model.mrw(`DRWT_MA_DBI, 8'h00);
    dbi_on = 1'b0;
  endtask : t_prog_b2b

  task automatic t_nop();
    logic [7:0] ops [2];
    ops = '{8'h03, 8'h7f};
    foreach (ops[i]) begin
      u_drwt_ctrl_model.pair(ops[i]);
      repeat (rl + 20) begin
        @(negedge mclk);
        check(obs, 21'h1c0000);
      end
    end
  endtask : t_nop

  task automatic t_fifo();
    u_drwt_ctrl_model.wr_fifo(8'h11);
    pulse(1'b0);
    u_drwt_ctrl_model.wr_fifo(8'h22);
    u_drwt_ctrl_model.wr_fifo(8'h33);
    pulse(1'b1);
    u_drwt_ctrl_model.wr_fifo(8'h44);
    read_fifo(8'h44, 1'b1);
    read_fifo(8'h33, 1'b1);
    read_fifo(8'h00, 1'b0);
    read_fifo(8'h00, 1'b0);
    read_fifo(8'h00, 1'b0);
    read_fifo(8'h44, 1'b1);
    u_drwt_ctrl_model.pair({2'b01, `DRWT_FN_RDCAL});
    expect_cal(16);
    read_fifo(8'h00, 1'b0);
    // array read wipes and moves both pointers: write lands at 2, reads start at 3
    u_drwt_ctrl_model.issue(drwt_pkg::DRWT_CMD_RD, 6'h00, 8'h00);
    u_drwt_ctrl_model.release_cmd();
    u_drwt_ctrl_model.wr_fifo(8'h55);
    for (int k = 0; k < 5; k++) begin
      read_fifo(8'h55, k == 4);
    end
    // cke low ignores commands and wipes the fifo
    u_drwt_ctrl_model.wr_fifo(8'h66);
    @(negedge mclk);
    cke_pin <= 1'b0;
    repeat (3) @(negedge mclk);
    u_drwt_ctrl_model.pair({2'b01, `DRWT_FN_RDCAL});
    repeat (rl + 20) begin
      @(negedge mclk);
      check(obs, 21'h1c0000);
    end
    cke_pin <= 1'b1;
    repeat (3) @(negedge mclk);
    read_fifo(8'h66, 1'b0);
  endtask : t_fifo

  initial begin
    n_fail     = 0;
    cmp_count  = 0;
    rst        = 1'b1;
    cke_pin    = 1'b1;
    pd_entry   = 1'b0;
    srpd_entry = 1'b0;
    rl         = 6'd5;
    wl         = 6'd3;
    repeat (10) @(negedge mclk);
    rst <= 1'b0;
    repeat (4) @(negedge mclk);
    check(obs, 21'h1c0000);
    t_defaults();
    t_prog_b2b();
    t_nop();
    t_fifo();
    finish_test();
  end

  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
endmodule : drwt_training_tb
